//--- core/pllc_pkg.sv
// ****************************************************************
// clock control constants
// ****************************************************************
package pllc_pkg;

  // register byte offsets
  localparam logic [11:0] RAW_STAT_OFS = 12'h050;
  localparam logic [11:0] MASK_OFS  = 12'h054;
  localparam logic [11:0] CLR_OFS   = 12'h058;
  localparam logic [11:0] RUN_CFG_OFS = 12'h060;
  localparam logic [11:0] XLAT_OFS  = 12'h064;
  localparam logic [11:0] RUN_EXT_OFS = 12'h070;

  // base configuration fields
  localparam int OSCSRC_LSB  = 4;
  localparam int OSCSRC_W    = 2;
  localparam int CRYS_LSB    = 6;
  localparam int CRYS_W      = 5;
  localparam int BYPASS_BIT  = 11;
  localparam int PWRDN_BIT   = 13;
  localparam int USEDIV_BIT  = 22;
  localparam int BDIV_LSB    = 23;
  localparam int BDIV_W      = 4;

  // extended configuration fields and the lock status bit
  localparam int OSCSRC2_LSB = 4;
  localparam int OSCSRC2_W   = 3;
  localparam int EDIV_W      = BDIV_W + 2;
  localparam int EDIV_LSB    = 23;
  localparam int USEEXT_BIT  = 31;
  localparam int LOCK_BIT    = 6;

  // reset values: pll powered down and bypassed, slowest base divisor
  localparam logic [31:0] RUN_CFG_RST = 32'h07c0_2b80;
  localparam logic [31:0] RUN_EXT_RST = 32'h07c0_2800;

  // encodings
  localparam logic [2:0]  OSC_RTC_ENC = 3'h7;
  localparam logic [15:0] LOCK_LOAD   = 16'h1200;
  localparam logic [7:0]  XLAT_BASE   = 8'h80;
  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;

  // raw clock source index
  typedef enum logic [2:0] {
    PLLC_SRC_MAIN = 3'b000,
    PLLC_SRC_INT  = 3'b001,
    PLLC_SRC_INT4 = 3'b010,
    PLLC_SRC_30K  = 3'b011,
    PLLC_SRC_RTC  = 3'b100,
    PLLC_SRC_PLL  = 3'b101
  } pllc_src_type;

endpackage

//--- core/pllc_lock_timer.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// settle-time down counter, stepped by main oscillator edges
// ****************************************************************
module pllc_lock_timer #(
  parameter int          CNT_W = 16,
  parameter logic [15:0] LOAD  = 16'h1200
) (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic osc_tick,
  input  wire logic load,
  output wire logic expired,
  output logic      done_ff
);

  if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
    $error("lock timer width out of range");
  end

  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] nxt_count;
  wire              last_step = osc_tick && (count_ff == CNT_W'(1));

  assign expired = (count_ff == '0);
  // a fresh trigger restarts the wait even mid-count
  assign nxt_count = load ? LOAD[CNT_W-1:0] :
                     (osc_tick && !expired) ? count_ff - CNT_W'(1) : count_ff;

  // counter and end-of-wait pulse
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count_ff <= '0;
      done_ff  <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      done_ff  <= last_step && !load;
    end
  end

endmodule
`default_nettype wire

//--- core/pllc_sysclk_div.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// system clock divider on source edge ticks
// ****************************************************************
module pllc_sysclk_div #(
  parameter int DIV_W = 6
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             src_tick,
  input  wire logic             halve,
  input  wire logic             div_on,
  input  wire logic [DIV_W-1:0] div_enc,
  output logic                  tick_ff
);

  if (DIV_W < 1 || DIV_W > 8) begin : g_bad_width
    $error("divider width out of range");
  end

  logic             half_ff;
  logic [DIV_W-1:0] cnt_ff;
  // pll path is halved before the divisor is applied
  wire stage_tick = halve ? (src_tick && half_ff) : src_tick;
  wire wrap       = (cnt_ff >= div_enc);
  // divisor is encoding plus one: count 0..enc
  wire out_tick   = div_on ? (stage_tick && wrap) : stage_tick;

  // prescaler, divide counter and output tick
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      half_ff <= 1'b0;
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      half_ff <= (halve && src_tick) ? !half_ff : half_ff;
      cnt_ff  <= !stage_tick ? cnt_ff : wrap ? '0 : cnt_ff + DIV_W'(1);
      tick_ff <= out_tick;
    end
  end

endmodule
`default_nettype wire

//--- core/pllc_top.sv
// Implementation choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module pllc_top
  import pllc_pkg::*;
#(
  parameter int          LOCK_W   = 16,
  parameter logic [15:0] LOCK_CNT = LOCK_LOAD
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        main_osc,
  input  wire logic        int_osc,
  input  wire logic        int_osc_div4,
  input  wire logic        osc_30k,
  input  wire logic        rtc_32k,
  input  wire logic        pll_clk,
  output logic             pll_powerdown,
  output logic             pll_ref_rtc,
  output logic [15:0]      pll_settings,
  output logic             sysclk_from_pll,
  output logic             sysclk_tick,
  output logic             pll_lock_irq
);

  // ****************************************************************
  // registers and state
  // ****************************************************************
  logic [31:0] cfg_ff;
  logic [31:0] cfg_ext_ff;
  logic [15:0] xlat_ff;
  logic        lock_flag_ff;
  logic        lock_mask_ff;
  logic        pwrdn_q_ff;
  logic [5:0]  src_q_ff;
  logic        wr_ph_ff;
  logic [11:0] wr_adr_ff;
  logic        sel_pll_ff;
  logic        irq_ff;
  logic        powerdown_ff;
  logic        ref_rtc_ff;
  logic [31:0] rdata_ff;
  logic        ready_ff;
  logic        nxt_lock_flag;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire         acc     = hsel && htrans[1] && hready;
  wire [11:0]  adr     = haddr[11:0];
  wire         rd_req  = acc && !hwrite;
  wire         wr_cfg  = wr_ph_ff && (wr_adr_ff == RUN_CFG_OFS);
  wire         wr_ext  = wr_ph_ff && (wr_adr_ff == RUN_EXT_OFS);
  wire         wr_mask = wr_ph_ff && (wr_adr_ff == MASK_OFS);
  wire         wr_clr  = wr_ph_ff && (wr_adr_ff == CLR_OFS);

  // ****************************************************************
  // effective configuration
  // ****************************************************************
  wire use_ext = cfg_ext_ff[USEEXT_BIT];
  // extended fields win over the base ones while in use
  wire eff_bypass = use_ext ? cfg_ext_ff[BYPASS_BIT] : cfg_ff[BYPASS_BIT];
  wire eff_pwrdn  = use_ext ? cfg_ext_ff[PWRDN_BIT] : cfg_ff[PWRDN_BIT];
  wire [EDIV_W-1:0] base_div = {2'b00, cfg_ff[BDIV_LSB +: BDIV_W]};
  // two extra bits give encodings up to 0x3f
  wire [EDIV_W-1:0] ext_div  = cfg_ext_ff[EDIV_LSB +: EDIV_W];
  wire [EDIV_W-1:0] eff_div  = use_ext ? ext_div : base_div;
  wire [2:0] ext_src  = cfg_ext_ff[OSCSRC2_LSB +: OSCSRC2_W];
  wire [1:0] base_src = cfg_ff[OSCSRC_LSB +: OSCSRC_W];
  wire       rtc_sel  = use_ext && (ext_src == OSC_RTC_ENC);
  wire [2:0] raw_src  = rtc_sel ? PLLC_SRC_RTC :
                        use_ext ? {1'b0, ext_src[1:0]} : {1'b0, base_src};

  // ****************************************************************
  // crystal translation and relock triggers
  // ****************************************************************
  wire [CRYS_W-1:0] crys_old = cfg_ff[CRYS_LSB +: CRYS_W];
  wire [CRYS_W-1:0] crys_new = hwdata[CRYS_LSB +: CRYS_W];
  // an identical rewrite of the crystal does not disturb the pll
  wire crystal_select_change = wr_cfg && (crys_new != crys_old);
  wire wake_pll    = pwrdn_q_ff && !eff_pwrdn;
  wire relock      = crystal_select_change || wake_pll;
  // translation: reference divider from crystal, multiplier is base minus crystal
  wire [7:0] xlat_r = {3'b000, crys_new};
  wire [7:0] xlat_f = XLAT_BASE - xlat_r;
  wire [15:0] nxt_xlat = crystal_select_change ? {xlat_f, xlat_r} : xlat_ff;

  // ****************************************************************
  // clock source edges
  // ****************************************************************
  wire [5:0] src_lvl  = {pll_clk, rtc_32k, osc_30k, int_osc_div4, int_osc, main_osc};
  wire [5:0] src_rise = src_lvl & ~src_q_ff;
  wire       osc_main_tick = src_rise[PLLC_SRC_MAIN];

  // ****************************************************************
  // settle timer
  // ****************************************************************
  wire lock_expired;
  wire lock_done;

  // counter steps on main oscillator edges only
  pllc_lock_timer #(
    .CNT_W (LOCK_W),
    .LOAD  (LOCK_CNT)
  ) u_lock (
    .clock    (clock),
    .resetn   (resetn),
    .osc_tick (osc_main_tick),
    .load     (relock),
    .expired  (lock_expired),
    .done_ff  (lock_done)
  );

  // pll counts as a source only when powered and settled
  wire pll_usable = !eff_pwrdn && lock_expired && !relock;
  // selected pll waits on the oscillator until settled
  wire nxt_sel_pll = !eff_bypass && pll_usable;
  wire src_tick    = sel_pll_ff ? src_rise[PLLC_SRC_PLL] : src_rise[raw_src];

  // ****************************************************************
  // system clock divider
  // ****************************************************************
  pllc_sysclk_div #(
    .DIV_W (EDIV_W)
  ) u_div (
    .clock    (clock),
    .resetn   (resetn),
    .src_tick (src_tick),
    .halve    (sel_pll_ff),
    .div_on   (sel_pll_ff || cfg_ff[USEDIV_BIT]),
    .div_enc  (eff_div),
    .tick_ff  (sysclk_tick)
  );

  // ****************************************************************
  // lock flag, readback mux
  // ****************************************************************
  // a lock arriving with the clear write still sets the flag
  assign nxt_lock_flag = lock_done ? 1'b1 :
                         (wr_clr && hwdata[LOCK_BIT]) ? 1'b0 : lock_flag_ff;
  wire [31:0] flag_word = ZERO_WORD | (32'(lock_flag_ff) << LOCK_BIT);
  wire [31:0] mask_word = ZERO_WORD | (32'(lock_mask_ff) << LOCK_BIT);
  wire [31:0] rd_word = (adr == RUN_CFG_OFS)  ? cfg_ff :
                        (adr == RUN_EXT_OFS)  ? cfg_ext_ff :
                        (adr == XLAT_OFS)     ? {16'h0000, xlat_ff} :
                        (adr == RAW_STAT_OFS) ? flag_word :
                        (adr == MASK_OFS) ? mask_word :
                        (adr == CLR_OFS)  ? (flag_word & mask_word) : ZERO_WORD;

  // bus phase tracking and read data
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_ph_ff  <= 1'b0;
      wr_adr_ff <= 12'h000;
      rdata_ff  <= ZERO_WORD;
      ready_ff  <= 1'b0;
    end else begin
      wr_ph_ff  <= acc && hwrite;
      wr_adr_ff <= acc ? adr : wr_adr_ff;
      rdata_ff  <= rd_req ? rd_word : rdata_ff;
      ready_ff  <= 1'b1;
    end
  end

  // configuration registers; pll starts powered down and bypassed
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg_ff       <= RUN_CFG_RST;
      cfg_ext_ff   <= RUN_EXT_RST;
      xlat_ff      <= 16'h0000;
      lock_mask_ff <= 1'b0;
    end else begin
      cfg_ff       <= wr_cfg ? hwdata : cfg_ff;
      cfg_ext_ff   <= wr_ext ? hwdata : cfg_ext_ff;
      xlat_ff      <= nxt_xlat;
      lock_mask_ff <= wr_mask ? hwdata[LOCK_BIT] : lock_mask_ff;
    end
  end

  // status and pll control outputs
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lock_flag_ff <= 1'b0;
      pwrdn_q_ff   <= 1'b1;
      src_q_ff     <= 6'h00;
      sel_pll_ff   <= 1'b0;
      irq_ff       <= 1'b0;
      powerdown_ff <= 1'b1;
      ref_rtc_ff   <= 1'b0;
    end else begin
      lock_flag_ff <= nxt_lock_flag;
      pwrdn_q_ff   <= eff_pwrdn;
      src_q_ff     <= src_lvl;
      sel_pll_ff   <= nxt_sel_pll;
      irq_ff       <= nxt_lock_flag && lock_mask_ff;
      powerdown_ff <= eff_pwrdn;
      ref_rtc_ff   <= rtc_sel;
    end
  end

  assign hreadyout       = ready_ff;
  assign hresp           = 1'b0 & ready_ff;
  assign hrdata          = rdata_ff;
  assign pll_powerdown   = powerdown_ff;
  assign pll_ref_rtc     = ref_rtc_ff;
  assign pll_settings    = xlat_ff;
  assign sysclk_from_pll = sel_pll_ff;
  assign pll_lock_irq    = irq_ff;

endmodule
`default_nettype wire

//--- bench/pllc_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// port checker for the clock control block
// ****************************************************************
module pllc_monitor #(
  parameter logic [15:0] LOCK_CNT = 16'h1200
) (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        pll_powerdown,
  input wire logic        pll_ref_rtc,
  input wire logic [15:0] pll_settings,
  input wire logic        sysclk_from_pll
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // address phases accepted by the slave
  wire logic wr_taken = hsel && htrans[1] && hready && hwrite;
  wire logic rd_taken = hsel && htrans[1] && hready && !hwrite;
  logic [15:0] since_ff;
  logic        pd_ff;
  logic [15:0] set_ff;
  // cycles since the last relock cause, saturating so long runs never wrap
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      since_ff <= 16'h0000;
      pd_ff <= 1'b1;
      set_ff <= 16'h0000;
    end else begin
      pd_ff <= pll_powerdown;
      set_ff <= pll_settings;
      if ((pd_ff && !pll_powerdown) || (set_ff != pll_settings)) begin
        since_ff <= 16'h0000;
      end else if (since_ff != 16'hffff) begin
        since_ff <= since_ff + 16'h0001;
      end
    end
  end
  // a register write landed two or three edges ago
  sequence wr_recent;
    $past(wr_taken, 2) || $past(wr_taken, 3);
  endsequence
  property relock_gate;
    $rose(sysclk_from_pll) |-> since_ff >= LOCK_CNT;
  endproperty
  AST_HRESP_OKAY: assert property (hresp == 1'b0) else $error("error response");
  AST_READY_HIGH: assert property ($past(resetn) |-> hreadyout) else $error("wait state");
  AST_RDATA_HOLD: assert property (!rd_taken |=> $stable(hrdata)) else $error("hrdata moved");
  AST_DOWN_NOPLL: assert property (pll_powerdown [*3] |-> !sysclk_from_pll)
    else $error("pll feeds while down");
  AST_RELOCK_GATE: assert property (relock_gate) else $error("pll used early");
  AST_XLAT_FORM: assert property (pll_settings != 16'h0000 |->
    pll_settings[15:8] == 8'h80 - pll_settings[7:0]) else $error("bad translation");
  AST_XLAT_WRITE: assert property ($changed(pll_settings) |-> wr_recent)
    else $error("settings moved alone");
  AST_RTC_WRITE: assert property ($changed(pll_ref_rtc) |-> wr_recent)
    else $error("reference moved alone");
  AST_PWRUP_WRITE: assert property ($fell(pll_powerdown) |-> wr_recent)
    else $error("pll woke alone");
endmodule

bind pllc_top pllc_monitor #(.LOCK_CNT(LOCK_CNT)) u_mon (.clock(clock), .resetn(resetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .pll_powerdown(pll_powerdown), .pll_ref_rtc(pll_ref_rtc),
  .pll_settings(pll_settings), .sysclk_from_pll(sysclk_from_pll));
`default_nettype wire

//--- bench/pll_lock_and_sysclk_divider_tb.sv
`timescale 1ns/100ps
`default_nettype none
module pll_lock_and_sysclk_divider_tb
  import pllc_pkg::*;
;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        osc = 1'b0;
  wire logic   hreadyout;
  wire logic   hresp;
  wire logic [31:0] hrdata;
  wire logic   pll_powerdown;
  wire logic   pll_ref_rtc;
  wire logic [15:0] pll_settings;
  wire logic   sysclk_from_pll;
  wire logic   sysclk_tick;
  wire logic   pll_lock_irq;
  int          err_count = 0;
  int          tests_run = 0;
  logic [31:0] rd;
  // ****************************************************************
  // clock, sources and design
  // ****************************************************************
  always #4 clock = ~clock;
  // every source rises each second cycle, so source ticks are 2 cycles apart
  always @(posedge clock) osc <= ~osc;
  pllc_top #(.LOCK_W(16), .LOCK_CNT(16'h0008)) dut (.clock(clock), .resetn(resetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .main_osc(osc), .int_osc(osc), .int_osc_div4(osc), .osc_30k(osc),
    .rtc_32k(osc), .pll_clk(osc), .pll_powerdown(pll_powerdown), .pll_ref_rtc(pll_ref_rtc),
    .pll_settings(pll_settings), .sysclk_from_pll(sysclk_from_pll),
    .sysclk_tick(sysclk_tick), .pll_lock_irq(pll_lock_irq));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one single word transfer; called just after a rising edge
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h00000, a};
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // cycles between two divided ticks; the bound keeps a dead divider finite
  task automatic period(output logic [31:0] n);
    int k;
    k = 0;
    while (sysclk_tick !== 1'b1 && k < 600) begin
      idle(1);
      k++;
    end
    n = 32'h0;
    do begin
      idle(1);
      n++;
    end while (sysclk_tick !== 1'b1 && n < 600);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    #80000;
    err_count++;
    finish_test();
  end
  initial begin
    idle(5);
    resetn <= 1'b1;
    idle(1);
    check("powerdown", pll_powerdown, 32'h1);
    bus(0, RUN_CFG_OFS, 0); check("run cfg", rd, RUN_CFG_RST);
    bus(0, RUN_EXT_OFS, 0); check("run cfg ext", rd, RUN_EXT_RST);
    bus(0, XLAT_OFS, 0); check("xlat", rd, ZERO_WORD);
    bus(1, RAW_STAT_OFS, 32'hffff_ffff);
    bus(0, RAW_STAT_OFS, 0); check("raw stat ro", rd, ZERO_WORD);
    bus(0, 12'h100, 0); check("unmapped", rd, ZERO_WORD);
    $display("test reset done");
    // crystal 0x10, bypassed and down, base divisor /4; main osc runs throughout
    bus(1, RUN_CFG_OFS, 32'h01c0_2c00);
    bus(0, XLAT_OFS, 0); check("xlat", rd, 32'h7010);
    check("settings", pll_settings, 32'h7010);
    idle(60);
    bus(0, RAW_STAT_OFS, 0); check("relock crystal", rd, 32'h40);
    bus(1, CLR_OFS, 32'h40);
    bus(1, RUN_CFG_OFS, 32'h01c0_2c00);
    idle(60);
    bus(0, RAW_STAT_OFS, 0); check("same crystal", rd, ZERO_WORD);
    period(rd); period(rd); check("raw div", rd, 32'd8);
    check("bypass", sysclk_from_pll, 32'h0);
    $display("test crystal done");
    // power up and select the pll in one write; encoding 3 avoids reserved ones
    bus(1, RUN_CFG_OFS, 32'h01c0_0400);
    idle(1);
    check("wakeup", pll_powerdown, 32'h0);
    check("held off", sysclk_from_pll, 32'h0);
    bus(0, RAW_STAT_OFS, 0); check("no lock yet", rd, ZERO_WORD);
    for (int k = 0; k < 100 && sysclk_from_pll !== 1'b1; k++) idle(1);
    check("switched", sysclk_from_pll, 32'h1);
    bus(0, RAW_STAT_OFS, 0); check("lock flag", rd, 32'h40);
    bus(1, MASK_OFS, 32'h40);
    idle(3);
    check("lock irq", pll_lock_irq, 32'h1);
    bus(0, CLR_OFS, 0); check("masked", rd, 32'h40);
    period(rd); period(rd); check("pll div", rd, 32'd16);
    $display("test pll done");
    // extended register: rtc source, bypassed, divisor /64
    bus(1, RUN_EXT_OFS, 32'h9f80_0870);
    idle(3);
    check("rtc ref", pll_ref_rtc, 32'h1);
    check("ext bypass", sysclk_from_pll, 32'h0);
    bus(0, RUN_EXT_OFS, 0); check("ext readback", rd, 32'h9f80_0870);
    period(rd); period(rd); check("ext div", rd, 32'd128);
    $display("test extended done");
    finish_test();
  end
endmodule
`default_nettype wire
